// File: rtl/cwpv_wait_unit.sv
/*
 Per-core wait unit: pin-not-equal wait and video hand-over wait, with an
 Avalon-MM register slave for configuration and status.
 Assumes the core issues one wait command at a time while exec_ready is high,
 the pins are asynchronous, and the video generator runs on core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module cwpv_wait_unit #(
    parameter bit PORT_B_PRESENT = 1'b0
) (
    input wire logic core_clk,
    input wire logic nrst,

    // instruction side
    input wire logic exec_valid,
    input wire cwpv_pkg::cwpv_cmd_t exec_cmd,
    output logic exec_ready,
    output logic core_stall,
    output logic core_resume,
    output logic core_low_power,

    // pins
    input wire logic [cwpv_pkg::PIN_W-1:0] port_a_inputs,
    input wire logic [cwpv_pkg::PIN_W-1:0] port_b_inputs,

    // video generator
    input wire logic vid_ready,
    output cwpv_pkg::cwpv_vid_t vid_out,

    // Avalon-MM slave
    input wire logic [cwpv_pkg::AV_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // ==========================================================
    // state
    typedef struct packed {
        cwpv_pkg::cwpv_state_t st;
        cwpv_pkg::cwpv_cmd_t cmd;
        logic [cwpv_pkg::PIN_W-1:0] pa_meta;
        logic [cwpv_pkg::PIN_W-1:0] pa_sync;
        logic [cwpv_pkg::PIN_W-1:0] pb_meta;
        logic [cwpv_pkg::PIN_W-1:0] pb_sync;
        logic resume;
        cwpv_pkg::cwpv_vid_t vid;
        logic [1:0] cfg;
        logic [31:0] stall_cnt;
        logic av_ack;
        logic [31:0] av_rdata;
    } cwpv_regs_t;

    cwpv_regs_t r;
    cwpv_regs_t next_r;

    logic pins_differ;
    logic [31:0] fmt_colors;
    logic [31:0] fmt_pixels;
    logic [5:0] fmt_pixel_count;
    logic av_req;
    logic [31:0] status_word;
    logic [31:0] read_mux;

    // ==========================================================
    // helpers
    cwpv_pin_cmp #(
        .PORT_B_PRESENT(PORT_B_PRESENT)
    ) u_pin_cmp (
        .port_a_inputs(r.pa_sync),
        .port_b_inputs(r.pb_sync),
        .state(r.cmd.state),
        .mask(r.cmd.mask),
        .port_sel(r.cmd.port),
        .differ(pins_differ)
    );

    cwpv_vid_fmt u_vid_fmt (
        .colors_in(r.cmd.colors),
        .pixels_in(r.cmd.pixels),
        .two_colour(r.cfg[cwpv_pkg::CFG_TWO_COLOUR_BIT]),
        .vga(r.cfg[cwpv_pkg::CFG_VGA_BIT]),
        .colors_out(fmt_colors),
        .pixels_out(fmt_pixels),
        .pixel_count(fmt_pixel_count)
    );

    // ==========================================================
    // outputs
    // stall is decoded from the state flop so it rises the cycle after issue
    assign exec_ready = (r.st == cwpv_pkg::CWPV_IDLE);
    assign core_stall = (r.st != cwpv_pkg::CWPV_IDLE);
    assign core_low_power = core_stall;
    assign core_resume = r.resume;
    assign vid_out = r.vid;
    assign av_req = avs_read | avs_write;
    assign avs_waitrequest = av_req & ~r.av_ack;
    assign avs_readdata = r.av_rdata;

    // ==========================================================
    // register read mux
    always_comb begin
        status_word = '0;
        status_word[cwpv_pkg::STAT_BUSY_BIT] = core_stall;
        status_word[cwpv_pkg::STAT_PIN_WAIT_BIT] = (r.st == cwpv_pkg::CWPV_PIN_WAIT);
        status_word[cwpv_pkg::STAT_VID_WAIT_BIT] = (r.st == cwpv_pkg::CWPV_VID_WAIT);
        status_word[cwpv_pkg::STAT_LOW_POWER_BIT] = core_low_power;
        status_word[cwpv_pkg::STAT_PIXCNT_LSB +: 6] =
            cwpv_pkg::cwpv_pix_count(r.cfg[cwpv_pkg::CFG_TWO_COLOUR_BIT]);
        case (avs_address)
            cwpv_pkg::OFF_CONFIG: begin
                read_mux = {30'h0000_0000, r.cfg};
            end
            cwpv_pkg::OFF_STATUS: begin
                read_mux = status_word;
            end
            cwpv_pkg::OFF_STALL_CNT: begin
                read_mux = r.stall_cnt;
            end
            cwpv_pkg::OFF_PINS: begin
                read_mux = r.pa_sync;
            end
            default: begin
                read_mux = 32'h0000_0000;
            end
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        next_r = r;
        next_r.resume = 1'b0;
        next_r.vid.take = 1'b0;
        next_r.av_ack = 1'b0;

        // two-flop synchronisers; only the second stage is used
        next_r.pa_meta = port_a_inputs;
        next_r.pa_sync = r.pa_meta;
        next_r.pb_meta = port_b_inputs;
        next_r.pb_sync = r.pb_meta;

        case (r.st)
            cwpv_pkg::CWPV_IDLE: begin
                if (exec_valid) begin
                    next_r.cmd = exec_cmd;
                    next_r.stall_cnt = cwpv_pkg::STALL_CNT_RESET;
                    if (exec_cmd.op == cwpv_pkg::CWPV_OP_VIDEO) begin
                        next_r.st = cwpv_pkg::CWPV_VID_WAIT;
                    end else begin
                        next_r.st = cwpv_pkg::CWPV_PIN_WAIT;
                    end
                end
            end
            cwpv_pkg::CWPV_PIN_WAIT: begin
                // saturates so a stuck wait does not appear short
                if (r.stall_cnt != 32'hFFFF_FFFF) begin
                    next_r.stall_cnt = r.stall_cnt + 32'h0000_0001;
                end
                if (pins_differ) begin
                    next_r.st = cwpv_pkg::CWPV_IDLE;
                    next_r.resume = 1'b1;
                end
            end
            cwpv_pkg::CWPV_VID_WAIT: begin
                // no timeout: an unstarted generator keeps the core here
                if (r.stall_cnt != 32'hFFFF_FFFF) begin
                    next_r.stall_cnt = r.stall_cnt + 32'h0000_0001;
                end
                if (vid_ready) begin
                    next_r.st = cwpv_pkg::CWPV_IDLE;
                    next_r.resume = 1'b1;
                    next_r.vid.take = 1'b1;
                    next_r.vid.colors = fmt_colors;
                    next_r.vid.pixels = fmt_pixels;
                    next_r.vid.pixel_count = fmt_pixel_count;
                end
            end
            default: begin
                next_r.st = cwpv_pkg::CWPV_IDLE;
            end
        endcase

        // one wait cycle, then answer; write lands on the answering edge
        if (av_req && !r.av_ack) begin
            next_r.av_ack = 1'b1;
            next_r.av_rdata = avs_read ? read_mux : 32'h0000_0000;
        end
        if (avs_write && r.av_ack && avs_address == cwpv_pkg::OFF_CONFIG && avs_byteenable[0]) begin
            next_r.cfg = avs_writedata[1:0];
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
            r.st <= cwpv_pkg::CWPV_IDLE;
            r.cfg <= cwpv_pkg::CFG_RESET;
            r.stall_cnt <= cwpv_pkg::STALL_CNT_RESET;
        end else begin
            r <= next_r;
        end
    end

endmodule : cwpv_wait_unit
`default_nettype wire

// File: inc/cwpv_pkg.sv
/*
 Package for the per-core wait unit: register map, field positions, reset values,
 command and state types shared by the wait unit and its two helper modules.
 Assumes one system clock and an asynchronous active-low reset in every user.
*/
`default_nettype none
package cwpv_pkg;

    // ==========================================================
    // widths
    localparam int unsigned PIN_W = 32;
    localparam int unsigned AV_ADDR_W = 5;
    localparam int unsigned ENTRY_W = 8;
    localparam int unsigned ENTRY_IGNORE_W = 2;
    localparam int unsigned TWO_COLOUR_W = 16;
    localparam logic [5:0] PIX_PER_WORD_4C = 6'h10;
    localparam logic [5:0] PIX_PER_WORD_2C = 6'h20;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [4:0] OFF_CONFIG = 5'h00;
    localparam logic [4:0] OFF_STATUS = 5'h04;
    localparam logic [4:0] OFF_STALL_CNT = 5'h08;
    localparam logic [4:0] OFF_PINS = 5'h0C;

    localparam int unsigned CFG_TWO_COLOUR_BIT = 0;
    localparam int unsigned CFG_VGA_BIT = 1;
    localparam logic [1:0] CFG_RESET = 2'h0;

    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_PIN_WAIT_BIT = 1;
    localparam int unsigned STAT_VID_WAIT_BIT = 2;
    localparam int unsigned STAT_LOW_POWER_BIT = 3;
    localparam int unsigned STAT_PIXCNT_LSB = 8;
    localparam logic [31:0] STALL_CNT_RESET = 32'h0000_0000;

    // ==========================================================
    // types
    typedef enum logic {
        CWPV_OP_PIN_NE = 1'b0,
        CWPV_OP_VIDEO = 1'b1
    } cwpv_op_t;

    typedef struct packed {
        cwpv_op_t op;
        logic [PIN_W-1:0] state;
        logic [PIN_W-1:0] mask;
        logic port;
        logic [31:0] colors;
        logic [31:0] pixels;
    } cwpv_cmd_t;

    typedef struct packed {
        logic take;
        logic [31:0] colors;
        logic [31:0] pixels;
        logic [5:0] pixel_count;
    } cwpv_vid_t;

    typedef enum logic [2:0] {
        CWPV_IDLE = 3'b001,
        CWPV_PIN_WAIT = 3'b010,
        CWPV_VID_WAIT = 3'b100
    } cwpv_state_t;

    // pixels carried by one word for the configured depth
    function automatic logic [5:0] cwpv_pix_count(input logic two_colour);
        cwpv_pix_count = two_colour ? PIX_PER_WORD_2C : PIX_PER_WORD_4C;
    endfunction : cwpv_pix_count

endpackage : cwpv_pkg
`default_nettype wire

// File: rtl/cwpv_pin_cmp.sv
/*
 Masked pin comparator for the pin-not-equal wait.
 Assumes its port inputs are already synchronised to the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module cwpv_pin_cmp #(
    parameter bit PORT_B_PRESENT = 1'b0
) (
    input wire logic [cwpv_pkg::PIN_W-1:0] port_a_inputs,
    input wire logic [cwpv_pkg::PIN_W-1:0] port_b_inputs,
    input wire logic [cwpv_pkg::PIN_W-1:0] state,
    input wire logic [cwpv_pkg::PIN_W-1:0] mask,
    input wire logic port_sel,
    output logic differ
);
    logic [cwpv_pkg::PIN_W-1:0] selected;

    // ==========================================================
    // compare
    // an absent second port reads as all low
    always_comb begin
        if (port_sel && PORT_B_PRESENT) begin
            selected = port_b_inputs;
        end else if (port_sel) begin
            selected = '0;
        end else begin
            selected = port_a_inputs;
        end
        differ = ((selected & mask) != state);
    end
endmodule : cwpv_pin_cmp
`default_nettype wire

// File: rtl/cwpv_vid_fmt.sv
/*
 Formats a colour word and pixel word for hand-over to the video generator.
 Assumes depth and VGA flags come from the configuration register.
*/
`timescale 1ns/1ns
`default_nettype none
module cwpv_vid_fmt (
    input wire logic [31:0] colors_in,
    input wire logic [31:0] pixels_in,
    input wire logic two_colour,
    input wire logic vga,
    output logic [31:0] colors_out,
    output logic [31:0] pixels_out,
    output logic [5:0] pixel_count
);
    // ==========================================================
    // format
    always_comb begin
        colors_out = colors_in;
        if (two_colour) begin
            colors_out[31:cwpv_pkg::TWO_COLOUR_W] = '0;
        end
        if (vga) begin
            // drop don't-care bits so the generator never sees stale values
            for (int i = 0; i < 4; i++) begin
                colors_out[i*cwpv_pkg::ENTRY_W +: cwpv_pkg::ENTRY_IGNORE_W] = '0;
            end
        end
        pixels_out = pixels_in;
        pixel_count = cwpv_pkg::cwpv_pix_count(two_colour);
    end
endmodule : cwpv_vid_fmt
`default_nettype wire

// File: dv/cwpv_wait_unit_assertions.sv
/*
 Checker for the wait unit: stall, resume, video hand-over timing.
 Assumes one clock domain; it sees only the unit's own ports.
*/
`timescale 1ns/1ns
`default_nettype none
module cwpv_wait_unit_chk (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic exec_valid,
    input wire cwpv_pkg::cwpv_cmd_t exec_cmd,
    input wire logic exec_ready,
    input wire logic core_stall,
    input wire logic core_resume,
    input wire logic core_low_power,
    input wire logic vid_ready,
    input wire cwpv_pkg::cwpv_vid_t vid_out
);
    // ==========================================================
    // helper: which kind of wait is running
    logic vid_mode;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            vid_mode <= 1'b0;
        end else if (exec_valid && exec_ready) begin
            vid_mode <= (exec_cmd.op == cwpv_pkg::CWPV_OP_VIDEO);
        end
    end
    // ==========================================================
    // checks
    chk_low_power_eq: assert property (core_low_power == core_stall)
        else $error("low power differs from stall");
    chk_ready_idle: assert property (exec_ready != core_stall)
        else $error("ready while stalled");
    chk_issue_stall: assert property (exec_valid && exec_ready |=> core_stall && !exec_ready)
        else $error("no stall after issue");
    chk_resume_end: assert property (core_resume |-> !core_stall && $past(core_stall))
        else $error("resume without stall end");
    chk_resume_once: assert property (core_resume |=> !core_resume)
        else $error("resume longer than one cycle");
    chk_vid_release: assert property (vid_mode && core_stall && vid_ready |=> vid_out.take && core_resume)
        else $error("no hand-over after ready");
    chk_vid_hold: assert property (vid_mode && core_stall && !vid_ready |=> core_stall && !vid_out.take)
        else $error("video wait left early");
    chk_take_cause: assert property (vid_out.take |-> vid_mode && $past(vid_ready) && $past(core_stall))
        else $error("stray hand-over");
endmodule : cwpv_wait_unit_chk
bind cwpv_wait_unit cwpv_wait_unit_chk chk_u (.core_clk(core_clk), .nrst(nrst), .exec_valid(exec_valid),
    .exec_cmd(exec_cmd), .exec_ready(exec_ready), .core_stall(core_stall), .core_resume(core_resume),
    .core_low_power(core_low_power), .vid_ready(vid_ready), .vid_out(vid_out));
`default_nettype wire

// File: dv/cwpv_vid_gen_model.sv
/*
 Video generator model: raises ready gap+1 cycles after each take pulse, while enabled.
 Assumes it shares core_clk with the wait unit.
*/
`timescale 1ns/1ns
`default_nettype none
module cwpv_vid_gen_model (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic enable,
    input wire logic [7:0] gap,
    input wire logic take,
    output logic vid_ready
);
    logic [7:0] cnt;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 8'h00;
            vid_ready <= 1'b0;
        end else if (take) begin
            cnt <= gap;
            vid_ready <= 1'b0;
        end else if (enable && !vid_ready) begin
            if (cnt == 8'h00) begin
                vid_ready <= 1'b1;
            end else begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule : cwpv_vid_gen_model
`default_nettype wire

// File: dv/testbench.sv
/*
 Testbench for the wait unit: bus setup, video rows, pin waits, resets.
 Assumes the generator model and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
    typedef struct packed {
        logic tc;
        logic vga;
        logic [7:0] gap;
        logic [31:0] colors;
        logic [31:0] pixels;
    } cwpv_row_t;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic exec_valid = 1'b0;
    cwpv_pkg::cwpv_cmd_t exec_cmd = '0;
    logic exec_ready, core_stall, core_resume, core_low_power, vid_ready, avs_waitrequest;
    logic [31:0] pins = 32'h0000_0000;
    cwpv_pkg::cwpv_vid_t vid_out;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic gen_en = 1'b0;
    logic [7:0] gap = 8'h00;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, rd;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int n;
    cwpv_row_t rows [4] = '{'{1'b0, 1'b0, 8'h00, 32'h1357_9BDF, 32'hA5A5_0F0F},
        '{1'b0, 1'b1, 8'h03, 32'hFFFF_FFFF, 32'h0123_4567}, '{1'b1, 1'b0, 8'h07, 32'hDEAD_BEEF, 32'hFFFF_0000},
        '{1'b1, 1'b1, 8'h01, 32'h8765_43FF, 32'h5555_AAAA}};
    always #4 core_clk = ~core_clk;
    // port b tied high: absent port must still read as zero
    cwpv_wait_unit dut_u (.core_clk(core_clk), .nrst(nrst), .exec_valid(exec_valid), .exec_cmd(exec_cmd),
        .exec_ready(exec_ready), .core_stall(core_stall), .core_resume(core_resume),
        .core_low_power(core_low_power), .port_a_inputs(pins), .port_b_inputs(32'hFFFF_FFFF),
        .vid_ready(vid_ready), .vid_out(vid_out), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    cwpv_vid_gen_model gen_u (.core_clk(core_clk), .nrst(nrst), .enable(gen_en), .gap(gap),
        .take(vid_out.take), .vid_ready(vid_ready));
    // ==========================================================
    // tasks
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        // waitrequest and read data are looked at on the rising edge only; the bench timeout ends a hang
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic issue(input cwpv_pkg::cwpv_op_t op, input logic [31:0] s, input logic [31:0] m,
        input logic p, input logic [31:0] c, input logic [31:0] x);
        @(posedge core_clk);
        exec_cmd <= '{op, s, m, p, c, x};
        exec_valid <= 1'b1;
        @(posedge core_clk);
        exec_valid <= 1'b0;
    endtask : issue
    task automatic wait_res(input int limit);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (core_resume !== 1'b1 && n < limit);
    endtask : wait_res
    function automatic logic [31:0] exp_col(input cwpv_row_t r);
        exp_col = r.colors;
        if (r.tc) begin
            exp_col[31:16] = 16'h0000;
        end
        if (r.vga) begin
            exp_col = exp_col & 32'hFCFC_FCFC;
        end
    endfunction : exp_col
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    // ==========================================================
    // sequence
    initial begin
        repeat (6) @(posedge core_clk);
        chk("ready in reset", 32'h1, exec_ready);
        nrst <= 1'b1;
        bus(1'b0, cwpv_pkg::OFF_CONFIG, 32'h0);
        chk("config reset", 32'h0, rd);
        bus(1'b0, 5'h1C, 32'h0);
        chk("unmapped read", 32'h0, rd);
        // generator not started yet, so this wait must hang
        issue(cwpv_pkg::CWPV_OP_VIDEO, 32'h0, 32'h0, 1'b0, 32'h1, 32'h2);
        wait_res(30);
        chk("stall unstarted", 32'h1, core_stall);
        chk("low power", 32'h1, core_low_power);
        @(posedge core_clk);
        gen_en <= 1'b1;
        wait_res(10);
        chk("resume after start", 32'h1, core_resume);
        foreach (rows[i]) begin
            bus(1'b1, cwpv_pkg::OFF_CONFIG, {30'h0, rows[i].vga, rows[i].tc});
            gap <= rows[i].gap;
            issue(cwpv_pkg::CWPV_OP_VIDEO, 32'h0, 32'h0, 1'b0, rows[i].colors, rows[i].pixels);
            wait_res(300);
            chk("take", 32'h1, vid_out.take);
            chk("colors", exp_col(rows[i]), vid_out.colors);
            chk("pixels", rows[i].pixels, vid_out.pixels);
            chk("count", rows[i].tc ? 32'h20 : 32'h10, vid_out.pixel_count);
            chk("stall after take", 32'h0, core_stall);
        end
        bus(1'b0, cwpv_pkg::OFF_STATUS, 32'h0);
        chk("status pixels", 32'h20, rd[13:8]);
        pins <= 32'h0000_0004;
        repeat (3) @(posedge core_clk);
        issue(cwpv_pkg::CWPV_OP_PIN_NE, 32'h4, 32'hC, 1'b0, 32'h0, 32'h0);
        wait_res(10);
        chk("pins equal hold", 32'h1, core_stall);
        @(posedge core_clk);
        pins <= 32'h0000_0007;
        wait_res(8);
        chk("unmasked ignored", 32'h1, core_stall);
        @(posedge core_clk);
        pins <= 32'h0000_000C;
        wait_res(6);
        chk("pins differ resume", 32'h1, core_resume);
        bus(1'b0, cwpv_pkg::OFF_PINS, 32'h0);
        chk("pins register", 32'h0000_000C, rd);
        issue(cwpv_pkg::CWPV_OP_PIN_NE, 32'h0, 32'hFFFF_FFFF, 1'b1, 32'h0, 32'h0);
        wait_res(10);
        chk("absent port equal", 32'h1, core_stall);
        @(posedge core_clk);
        nrst <= 1'b0;
        @(negedge core_clk);
        chk("reset clears stall", 32'h0, core_stall);
        @(posedge core_clk);
        nrst <= 1'b1;
        issue(cwpv_pkg::CWPV_OP_PIN_NE, 32'h1, 32'h1, 1'b1, 32'h0, 32'h0);
        wait_res(8);
        chk("absent port differ", 32'h1, core_resume);
        // released on the first compare, so exactly one stalled cycle
        bus(1'b0, cwpv_pkg::OFF_STALL_CNT, 32'h0);
        chk("stall count", 32'h0000_0001, rd);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
